//--- logic/ovd_pkg.sv
// Purpose: Shared constants and state type for the output volume bank.
// Assumes: 7-bit register index, 9-bit register data.
// Notes:   Right speaker register is kept so the speaker pair can be
//          applied together.
package ovd_pkg;

   // ---------------------------------------------------------------
   // Register indices
   // ---------------------------------------------------------------
   localparam logic [6:0] OFF_LEFT_PHONES   = 7'h34;
   localparam logic [6:0] OFF_RIGHT_PHONES  = 7'h35;
   localparam logic [6:0] OFF_LEFT_SPEAKER  = 7'h36;
   localparam logic [6:0] OFF_RIGHT_SPEAKER = 7'h37;

   // ---------------------------------------------------------------
   // Field layout
   // ---------------------------------------------------------------
   localparam int GAIN_LSB = 0;
   localparam int GAIN_MSB = 5;
   localparam int MUTE_BIT = 6;
   localparam int ZC_BIT = 7;
   localparam int UPDATE_BIT = 8;

   // ---------------------------------------------------------------
   // Reset values and gain scale
   // ---------------------------------------------------------------
   localparam logic [8:0] VOLUME_RESET = 9'h039;
   localparam logic [7:0] SETTING_RESET = 8'h39;
   localparam logic [5:0] GAIN_ZERO_DB = 6'h39;
   localparam int GAIN_MIN_DB = -57;
   localparam int GAIN_STEP_DB = 1;

   // Channel order: 0 left phones, 1 right phones, 2 left spk, 3 right
   localparam int NUM_CHANNELS = 4;

   typedef struct packed {
      logic [3:0][7:0] pend;
      logic [3:0][7:0] act;
      logic [3:0][5:0] applied;
      logic [8:0] rdata;
      logic [3:0] zcMeta;
      logic [3:0] zcSync;
   } ovd_state_t;

endpackage : ovd_pkg

//--- logic/ovd_volume_regs.sv
// Purpose: Double-buffered headphone and speaker volume registers with
//          zero-cross gated gain application.
// Assumes: Zero-cross indications arrive asynchronously, one per channel,
//          high while the signal is near zero.
// Notes:   Read data is the last written setting; update bit reads 0.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps

// Behaviour
// - Left phones write, update clear: store pending, keep active setting.
// - Left phones write, update set: activate left and pending right.
// - Right phones write, update clear: store pending, active unchanged.
// - Right phones write, update set: activate right and pending left.
// - Left speaker write, update clear: store pending, active unchanged.
// - Left speaker write, update set: activate left and pending right.
// - Update bit qualifies its write only; never stored, reads zero.
// - Left phones zero-cross enable: 0 immediate, 1 wait for crossing.
// - Right phones zero-cross enable: 0 immediate, 1 wait for crossing.
// - Left speaker zero-cross enable: 0 immediate, 1 wait for crossing.
// - Left phones mute bit disconnects output from left mixer.
// - Right phones mute bit disconnects output from right mixer.
// - Left speaker mute bit puts speaker output in muted condition.
// - Gain code 0 is -57 dB, one dB per step, +6 dB at top.
// - Gain code 111001 is 0 dB and the default.
// - New gain applies only when update and zero-cross gating allow.
// - Right speaker write, update set: activate right and pending left.
module ovd_volume_regs
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [6:0] regAddr,
   input wire logic [8:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [8:0] regRdata,
   input wire logic [3:0] zeroCrossIn,
   output logic [5:0] leftPhonesGain,
   output logic leftPhonesMute,
   output logic [5:0] rightPhonesGain,
   output logic rightPhonesMute,
   output logic [5:0] leftSpeakerGain,
   output logic leftSpeakerMute,
   output logic [5:0] rightSpeakerGain,
   output logic rightSpeakerMute
);
   import ovd_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   localparam ovd_state_t STATE_RESET = '{
      pend: {4{SETTING_RESET}},
      act: {4{SETTING_RESET}},
      applied: {4{GAIN_ZERO_DB}},
      rdata: 9'h000,
      zcMeta: 4'h0,
      zcSync: 4'h0
   };

   ovd_state_t state_reg;
   ovd_state_t state_next;

   // Address decode: the four volume registers are contiguous
   logic hit;
   logic [6:0] addrDelta;
   logic [1:0] chan;
   logic [1:0] partner;

   assign addrDelta = regAddr - OFF_LEFT_PHONES;
   // Addresses below the bank wrap to large deltas; one compare covers both
   assign hit = (addrDelta <= (OFF_RIGHT_SPEAKER - OFF_LEFT_PHONES));
   assign chan = addrDelta[1:0];
   // Pairs are (0,1) and (2,3), so partner is the other low bit
   assign partner = chan ^ 2'h1;

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   // Write path, readback, synchroniser and zero-cross gate
   always_comb
   begin
      state_next = state_reg;
      // Two-stage synchroniser; only the second stage is looked at
      state_next.zcMeta = zeroCrossIn;
      state_next.zcSync = state_reg.zcMeta;
      // Read data stands for one cycle only; unmapped reads give zero
      state_next.rdata = 9'h000;
      if (regRead && hit)
      begin
         state_next.rdata = {1'b0, state_reg.pend[chan]};
      end
      if (regWrite && hit)
      begin
         // Shadow copy always takes the write
         state_next.pend[chan] = regWdata[7:0];
         if (regWdata[UPDATE_BIT])
         begin
            // Pair goes live together so left and right never skew
            state_next.act[chan] = regWdata[7:0];
            state_next.act[partner] = state_reg.pend[partner];
         end
      end
      // Gain follows the live setting only when the gate allows it
      for (int i = 0; i < NUM_CHANNELS; i++)
      begin
         if (!state_reg.act[i][ZC_BIT] || state_reg.zcSync[i])
         begin
            state_next.applied[i] =
               state_reg.act[i][GAIN_MSB:GAIN_LSB];
         end
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // Reset to 0 dB, unmuted, gating off
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg <= STATE_RESET;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Gain code is dB plus 57, applied directly to the analog stage
   assign leftPhonesGain = state_reg.applied[0];
   assign rightPhonesGain = state_reg.applied[1];
   assign leftSpeakerGain = state_reg.applied[2];
   assign rightSpeakerGain = state_reg.applied[3];
   // Mute is not zero-cross gated; it acts as soon as it is live
   assign leftPhonesMute = state_reg.act[0][MUTE_BIT];
   assign rightPhonesMute = state_reg.act[1][MUTE_BIT];
   assign leftSpeakerMute = state_reg.act[2][MUTE_BIT];
   assign rightSpeakerMute = state_reg.act[3][MUTE_BIT];
   assign regRdata = state_reg.rdata;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_lphones_hold_pending: assert property (
      @(posedge clk) disable iff (!arst_n)
      (regWrite && regAddr == OFF_LEFT_PHONES && !regWdata[UPDATE_BIT])
      |=> (state_reg.act[0] == $past(state_reg.act[0])) &&
          (state_reg.pend[0] == $past(regWdata[7:0])))
      else $error("left phones changed without update");

   a_lphones_pair_update: assert property (
      @(posedge clk) disable iff (!arst_n)
      (regWrite && regAddr == OFF_LEFT_PHONES && regWdata[UPDATE_BIT])
      |=> (state_reg.act[0] == $past(regWdata[7:0])) &&
          (state_reg.act[1] == $past(state_reg.pend[1])))
      else $error("phones pair not activated together");

   a_rphones_hold_pending: assert property (
      @(posedge clk) disable iff (!arst_n)
      (regWrite && regAddr == OFF_RIGHT_PHONES && !regWdata[UPDATE_BIT])
      |=> $stable(state_reg.act[1]))
      else $error("right phones changed without update");

   a_rphones_pair_update: assert property (
      @(posedge clk) disable iff (!arst_n)
      (regWrite && regAddr == OFF_RIGHT_PHONES && regWdata[UPDATE_BIT])
      |=> (state_reg.act[1] == $past(regWdata[7:0])) &&
          (state_reg.act[0] == $past(state_reg.pend[0])))
      else $error("right phones pair not activated together");

   a_lspk_hold_pending: assert property (
      @(posedge clk) disable iff (!arst_n)
      (regWrite && regAddr == OFF_LEFT_SPEAKER && !regWdata[UPDATE_BIT])
      |=> $stable(state_reg.act[2]) && $stable(leftSpeakerMute))
      else $error("left speaker changed without update");

   a_lspk_pair_update: assert property (
      @(posedge clk) disable iff (!arst_n)
      (regWrite && regAddr == OFF_LEFT_SPEAKER && regWdata[UPDATE_BIT])
      |=> (state_reg.act[2] == $past(regWdata[7:0])) &&
          (state_reg.act[3] == $past(state_reg.pend[3])))
      else $error("speaker pair not activated together");

   a_rspk_pair_update: assert property (
      @(posedge clk) disable iff (!arst_n)
      (regWrite && regAddr == OFF_RIGHT_SPEAKER && regWdata[UPDATE_BIT])
      |=> (state_reg.act[3] == $past(regWdata[7:0])) &&
          (state_reg.act[2] == $past(state_reg.pend[2])))
      else $error("right speaker pair not activated together");

   a_update_reads_zero: assert property (
      @(posedge clk) disable iff (!arst_n)
      (regWrite && hit) ##1 (regRead && regAddr == $past(regAddr))
      |=> (regRdata == {1'b0, $past(regWdata[7:0], 2)}))
      else $error("readback not last write with update clear");

   a_lphones_zc_immediate: assert property (
      @(posedge clk) disable iff (!arst_n)
      !state_reg.act[0][ZC_BIT]
      |=> (leftPhonesGain == $past(state_reg.act[0][GAIN_MSB:GAIN_LSB])))
      else $error("left phones gain not applied at once");

   a_rphones_zc_wait: assert property (
      @(posedge clk) disable iff (!arst_n)
      (state_reg.act[1][ZC_BIT] && !state_reg.zcSync[1])
      |=> $stable(rightPhonesGain))
      else $error("right phones gain moved before crossing");

   a_lspk_zc_cross: assert property (
      @(posedge clk) disable iff (!arst_n)
      (state_reg.act[2][ZC_BIT] && state_reg.zcSync[2])
      |=> (leftSpeakerGain == $past(state_reg.act[2][GAIN_MSB:GAIN_LSB])))
      else $error("left speaker gain missed crossing");

   a_lphones_mute_write: assert property (
      @(posedge clk) disable iff (!arst_n)
      (regWrite && regAddr == OFF_LEFT_PHONES && regWdata[UPDATE_BIT])
      |=> (leftPhonesMute == $past(regWdata[MUTE_BIT])))
      else $error("left phones mute not applied");

   a_zc_sync_delay: assert property (
      @(posedge clk) disable iff (!arst_n)
      (regWrite && regAddr == OFF_RIGHT_PHONES && regWdata[UPDATE_BIT] &&
       regWdata[ZC_BIT] && (regWdata[5:0] != rightPhonesGain))
      ##1 (!state_reg.zcSync[1]) |=> $stable(rightPhonesGain))
      else $error("gain changed with gating still closed");

   // Remaining double-buffer and mute checks; mute is never gated
   a_rspk_hold_pending: assert property (
      @(posedge clk) disable iff (!arst_n)
      (regWrite && regAddr == OFF_RIGHT_SPEAKER && !regWdata[UPDATE_BIT])
      |=> $stable(state_reg.act[3]) && $stable(rightSpeakerMute))
      else $error("right speaker changed without update");

   a_partner_mute_live: assert property (
      @(posedge clk) disable iff (!arst_n)
      (regWrite && regAddr == OFF_RIGHT_PHONES && regWdata[UPDATE_BIT])
      |=> (leftPhonesMute == $past(state_reg.pend[0][MUTE_BIT])))
      else $error("pending left phones mute not made live");

   a_rphones_mute_write: assert property (
      @(posedge clk) disable iff (!arst_n)
      (regWrite && regAddr == OFF_RIGHT_PHONES && regWdata[UPDATE_BIT])
      |=> (rightPhonesMute == $past(regWdata[MUTE_BIT])))
      else $error("right phones mute not applied");

   a_lspk_mute_write: assert property (
      @(posedge clk) disable iff (!arst_n)
      (regWrite && regAddr == OFF_LEFT_SPEAKER && regWdata[UPDATE_BIT])
      |=> (leftSpeakerMute == $past(regWdata[MUTE_BIT])))
      else $error("left speaker mute not applied");

   a_rspk_mute_write: assert property (
      @(posedge clk) disable iff (!arst_n)
      (regWrite && regAddr == OFF_RIGHT_SPEAKER && regWdata[UPDATE_BIT])
      |=> (rightSpeakerMute == $past(regWdata[MUTE_BIT])))
      else $error("right speaker mute not applied");

   // Gate per channel: open passes the live gain, closed holds the old one
   a_lphones_zc_wait: assert property (
      @(posedge clk) disable iff (!arst_n)
      (state_reg.act[0][ZC_BIT] && !state_reg.zcSync[0])
      |=> $stable(leftPhonesGain))
      else $error("left phones gain moved before crossing");

   a_lphones_zc_cross: assert property (
      @(posedge clk) disable iff (!arst_n)
      (state_reg.act[0][ZC_BIT] && state_reg.zcSync[0])
      |=> (leftPhonesGain == $past(state_reg.act[0][GAIN_MSB:GAIN_LSB])))
      else $error("left phones gain missed crossing");

   a_rphones_zc_immediate: assert property (
      @(posedge clk) disable iff (!arst_n)
      !state_reg.act[1][ZC_BIT]
      |=> (rightPhonesGain == $past(state_reg.act[1][GAIN_MSB:GAIN_LSB])))
      else $error("right phones gain not applied at once");

   a_rphones_zc_cross: assert property (
      @(posedge clk) disable iff (!arst_n)
      (state_reg.act[1][ZC_BIT] && state_reg.zcSync[1])
      |=> (rightPhonesGain == $past(state_reg.act[1][GAIN_MSB:GAIN_LSB])))
      else $error("right phones gain missed crossing");

   a_lspk_zc_immediate: assert property (
      @(posedge clk) disable iff (!arst_n)
      !state_reg.act[2][ZC_BIT]
      |=> (leftSpeakerGain == $past(state_reg.act[2][GAIN_MSB:GAIN_LSB])))
      else $error("left speaker gain not applied at once");

   a_lspk_zc_wait: assert property (
      @(posedge clk) disable iff (!arst_n)
      (state_reg.act[2][ZC_BIT] && !state_reg.zcSync[2])
      |=> $stable(leftSpeakerGain))
      else $error("left speaker gain moved before crossing");

   a_rspk_zc_immediate: assert property (
      @(posedge clk) disable iff (!arst_n)
      !state_reg.act[3][ZC_BIT]
      |=> (rightSpeakerGain == $past(state_reg.act[3][GAIN_MSB:GAIN_LSB])))
      else $error("right speaker gain not applied at once");

   a_rspk_zc_wait: assert property (
      @(posedge clk) disable iff (!arst_n)
      (state_reg.act[3][ZC_BIT] && !state_reg.zcSync[3])
      |=> $stable(rightSpeakerGain))
      else $error("right speaker gain moved before crossing");

   a_rspk_zc_cross: assert property (
      @(posedge clk) disable iff (!arst_n)
      (state_reg.act[3][ZC_BIT] && state_reg.zcSync[3])
      |=> (rightSpeakerGain == $past(state_reg.act[3][GAIN_MSB:GAIN_LSB])))
      else $error("right speaker gain missed crossing");

   // Readback stands one cycle; unmapped accesses change nothing
   a_read_one_cycle: assert property (
      @(posedge clk) disable iff (!arst_n)
      !regRead |=> (regRdata == 9'h000))
      else $error("read data outlived its cycle");

   a_unmapped_read_zero: assert property (
      @(posedge clk) disable iff (!arst_n)
      (regRead && !hit) |=> (regRdata == 9'h000))
      else $error("unmapped read returned data");

   a_unmapped_ignored: assert property (
      @(posedge clk) disable iff (!arst_n)
      (regWrite && !hit)
      |=> $stable(state_reg.pend) && $stable(state_reg.act))
      else $error("unmapped write changed a register");

   // Reset values, seen at the first edge after release
   a_reset_gain_default: assert property (
      @(posedge clk)
      $rose(arst_n) |-> (leftPhonesGain == GAIN_ZERO_DB) &&
         (rightPhonesGain == GAIN_ZERO_DB) &&
         (leftSpeakerGain == GAIN_ZERO_DB) &&
         (rightSpeakerGain == GAIN_ZERO_DB))
      else $error("gain not at 0 dB default after reset");

   a_reset_mute_clear: assert property (
      @(posedge clk)
      $rose(arst_n) |-> !leftPhonesMute && !rightPhonesMute &&
         !leftSpeakerMute && !rightSpeakerMute &&
         (regRdata == 9'h000))
      else $error("mute or read data not clear after reset");

endmodule : ovd_volume_regs

//--- sim/ovd_volume_regs_tb.sv
// Purpose: Self-checking bench for the output volume register bank.
// Assumes: Inputs change by non-blocking assignment at the rising edge.
// Notes:   Zero-cross inputs stay low except in the gating tests.
`timescale 1ns/1ps
module ovd_volume_regs_tb;
   import ovd_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [6:0] regAddr = 7'h00;
   logic [8:0] regWdata = 9'h000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [3:0] zeroCrossIn = 4'h0;
   logic [8:0] regRdata;
   logic [5:0] leftPhonesGain, rightPhonesGain;
   logic [5:0] leftSpeakerGain, rightSpeakerGain;
   logic leftPhonesMute, rightPhonesMute;
   logic leftSpeakerMute, rightSpeakerMute;
   logic [27:0] outs;
   logic [6:0] qAddr [$];
   logic [8:0] qData [$];
   logic [8:0] qRd [$];
   logic [27:0] qExp [$];
   logic [5:0] oldGain [4] = '{6'h3F, 6'h01, 6'h00, 6'h07};
   int badCount = 0;
   int nChecks = 0;
   int cycles = 0;

   // -------------------------------------------------------------
   // Clock, design, helpers
   // -------------------------------------------------------------
   always #10 clk = ~clk;
   // Each channel packed as {mute, gain}
   assign outs = {leftPhonesMute, leftPhonesGain, rightPhonesMute,
      rightPhonesGain, leftSpeakerMute, leftSpeakerGain,
      rightSpeakerMute, rightSpeakerGain};

   ovd_volume_regs dut (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
      .regRdata(regRdata), .zeroCrossIn(zeroCrossIn),
      .leftPhonesGain(leftPhonesGain), .leftPhonesMute(leftPhonesMute),
      .rightPhonesGain(rightPhonesGain), .rightPhonesMute(rightPhonesMute),
      .leftSpeakerGain(leftSpeakerGain), .leftSpeakerMute(leftSpeakerMute),
      .rightSpeakerGain(rightSpeakerGain),
      .rightSpeakerMute(rightSpeakerMute));

   task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
      nChecks++;
      if (seen !== exp)
      begin
         badCount++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen,
            exp);
      end
   endtask : chk

   task automatic wrapUp;
      $display("checks %0d mismatches %0d", nChecks, badCount);
      if (badCount == 0 && nChecks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : wrapUp

   task automatic wr(input logic [6:0] a, input logic [8:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask : wr

   // Read data stands for one cycle only, then returns to zero
   task automatic rd(input logic [6:0] a, input logic [8:0] e);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 chk(28'(regRdata), 28'(e));
      @(posedge clk);
      #1 chk(28'(regRdata), 28'h0);
   endtask : rd

   task automatic add(input logic [6:0] a, input logic [8:0] w,
      input logic [6:0] lp, input logic [6:0] rp, input logic [6:0] ls,
      input logic [6:0] rs, input logic [8:0] r);
      qAddr.push_back(a);
      qData.push_back(w);
      qExp.push_back({lp, rp, ls, rs});
      qRd.push_back(r);
   endtask : add

   // Hang guard, well above the under two hundred cycles the run needs
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         badCount++;
         wrapUp();
      end
   end

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial
   begin
      add(7'h34, 9'h010, 7'h39, 7'h39, 7'h39, 7'h39, 9'h010);
      add(7'h35, 9'h050, 7'h39, 7'h39, 7'h39, 7'h39, 9'h050);
      add(7'h34, 9'h120, 7'h20, 7'h50, 7'h39, 7'h39, 9'h020);
      add(7'h35, 9'h13F, 7'h20, 7'h3F, 7'h39, 7'h39, 9'h03F);
      add(7'h34, 9'h000, 7'h20, 7'h3F, 7'h39, 7'h39, 9'h000);
      add(7'h35, 9'h101, 7'h00, 7'h01, 7'h39, 7'h39, 9'h001);
      add(7'h36, 9'h04A, 7'h00, 7'h01, 7'h39, 7'h39, 9'h04A);
      add(7'h37, 9'h005, 7'h00, 7'h01, 7'h39, 7'h39, 9'h005);
      add(7'h36, 9'h13F, 7'h00, 7'h01, 7'h3F, 7'h05, 9'h03F);
      add(7'h36, 9'h040, 7'h00, 7'h01, 7'h3F, 7'h05, 9'h040);
      add(7'h37, 9'h107, 7'h00, 7'h01, 7'h40, 7'h07, 9'h007);
      add(7'h38, 9'h1FF, 7'h00, 7'h01, 7'h40, 7'h07, 9'h000);
      add(7'h34, 9'h17F, 7'h7F, 7'h01, 7'h40, 7'h07, 9'h07F);
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      #1 chk(outs, {4{7'h39}});
      for (int a = 'h34; a <= 'h37; a++)
         rd(7'(a), VOLUME_RESET);
      for (int i = 0; i < qAddr.size(); i++)
      begin
         wr(qAddr[i], qData[i]);
         @(posedge clk);
         #1 chk(outs, qExp[i]);
         rd(qAddr[i], qRd[i]);
      end
      // Gain held back until the crossing, then applied
      for (int i = 0; i < 4; i++)
      begin
         wr(7'h34 + 7'(i), 9'h180 + 9'(i + 8));
         repeat (5) @(posedge clk);
         #1 chk(28'(outs[26 - 7 * i -: 6]), 28'(oldGain[i]));
         @(posedge clk);
         zeroCrossIn[i] <= 1'b1;
         repeat (4) @(posedge clk);
         #1 chk(28'(outs[26 - 7 * i -: 6]), 28'(i + 8));
         rd(7'h34 + 7'(i), 9'h080 + 9'(i + 8));
         @(posedge clk);
         zeroCrossIn <= 4'h0;
      end
      // Second reset in mid-run takes effect without a clock edge
      @(posedge clk);
      arst_n <= 1'b0;
      #1 chk(outs, {4{7'h39}});
      @(posedge clk);
      arst_n <= 1'b1;
      rd(7'h35, VOLUME_RESET);
      // Write then read with no gap; the read must see the fresh copy
      @(posedge clk);
      regAddr <= 7'h37;
      regWdata <= 9'h07E;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 chk(28'(regRdata), 28'h07E);
      // Left speaker update takes the muted right speaker live with it
      wr(7'h36, 9'h125);
      @(posedge clk);
      #1 chk(outs, {7'h39, 7'h39, 7'h25, 7'h7E});
      wrapUp();
   end
endmodule : ovd_volume_regs_tb
